// >>> timer_pkg.sv
// Constants, register map and mode encodings for the dual timer/counter.
package timer_pkg;

  // ************************************************************
  // Register map: printed indices and their APB byte addresses.
  // ************************************************************
  localparam int ADDR_W = 12; // Width of the APB address.
  localparam logic [7:0] IDX_CTRL = 8'h88; // Run, flag and type bits.
  localparam logic [7:0] IDX_MODE = 8'h89; // Gate, select, mode fields.
  localparam logic [7:0] IDX_TL0 = 8'h8A; // Timer 0 low count byte.
  localparam logic [7:0] IDX_TL1 = 8'h8B; // Timer 1 low count byte.
  localparam logic [7:0] IDX_TH0 = 8'h8C; // Timer 0 high count byte.
  localparam logic [7:0] IDX_TH1 = 8'h8D; // Timer 1 high count byte.
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MODE = {2'b00, IDX_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TL0 = {2'b00, IDX_TL0, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TL1 = {2'b00, IDX_TL1, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TH0 = {2'b00, IDX_TH0, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TH1 = {2'b00, IDX_TH1, 2'b00};

  // ************************************************************
  // Field positions inside the control register.
  // ************************************************************
  localparam int CTRL_TF1 = 7; // Timer 1 overflow flag.
  localparam int CTRL_TR1 = 6; // Timer 1 run bit.
  localparam int CTRL_TF0 = 5; // Timer 0 overflow flag.
  localparam int CTRL_TR0 = 4; // Timer 0 run bit.
  localparam int CTRL_IE1 = 3; // External interrupt 1 detect flag.
  localparam int CTRL_IT1 = 2; // External interrupt 1 type select.
  localparam int CTRL_IE0 = 1; // External interrupt 0 detect flag.
  localparam int CTRL_IT0 = 0; // External interrupt 0 type select.

  // ************************************************************
  // Field positions inside the mode register.
  // ************************************************************
  localparam int MODE_T1_GATE = 7; // Timer 1 gate bit.
  localparam int MODE_T1_CT = 6; // Timer 1 counter select.
  localparam int MODE_T1_LSB = 4; // Timer 1 mode field, low bit.
  localparam int MODE_T0_GATE = 3; // Timer 0 gate bit.
  localparam int MODE_T0_CT = 2; // Timer 0 counter select.
  localparam int MODE_T0_LSB = 0; // Timer 0 mode field, low bit.

  // ************************************************************
  // Reset values and timing.
  // ************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00; // Control clears on reset.
  localparam logic [7:0] MODE_RESET = 8'h00; // Mode clears on reset.
  localparam logic [7:0] COUNT_RESET = 8'h00; // Count bytes start at zero.
  localparam int OSC_PER_MCYCLE = 6; // Oscillator periods per cycle.
  localparam logic [2:0] MC_LAST = 3'(OSC_PER_MCYCLE - 1); // Last phase.

  // Operating modes selected by each two-bit mode field.
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_e;

endpackage

// >>> pin_sync.sv
// Two-flop synchroniser for the asynchronous timer pins.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 4 // Number of pins brought into the clock domain.
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels.
  output logic [WIDTH-1:0] pin_out // Synchronised levels.
);

  // ************************************************************
  // Synchroniser stages.
  // ************************************************************
  logic [WIDTH-1:0] stage1_reg; // First stage, read only by stage two.
  logic [WIDTH-1:0] stage2_reg; // Second stage, safe to use.

  // Both stages reset high so that idle pins read inactive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign pin_out = stage2_reg;

endmodule // pin_sync

`default_nettype wire

// >>> dual_timer_counter.sv
// Dual 16-bit timer/counter with overflow and external interrupt flags.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter (
  input wire logic pclk, // Oscillator clock, 25 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write direction.
  input wire logic [timer_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready, always high.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic timer0_count_pin, // Timer 0 external count input.
  input wire logic timer1_count_pin, // Timer 1 external count input.
  input wire logic external_interrupt0_pin_n, // External int 0, low.
  input wire logic external_interrupt1_pin_n, // External int 1, low.
  input wire logic timer0_vector_ack, // CPU vectored to timer 0.
  input wire logic timer1_vector_ack, // CPU vectored to timer 1.
  input wire logic extint0_vector_ack, // CPU vectored to ext int 0.
  input wire logic extint1_vector_ack, // CPU vectored to ext int 1.
  output logic timer0_overflow_flag, // Timer 0 overflow flag.
  output logic timer1_overflow_flag, // Timer 1 overflow flag.
  output logic extint0_detect_flag, // External interrupt 0 flag.
  output logic extint1_detect_flag, // External interrupt 1 flag.
  output logic timer1_overflow_pulse // Timer 1 rollover, for baud use.
);
  import timer_pkg::*;

  // ************************************************************
  // Pin synchronisation.
  // ************************************************************
  logic [3:0] pins_s; // Synchronised count and interrupt pins.
  logic cnt0_s; // Timer 0 count pin, synchronised.
  logic cnt1_s; // Timer 1 count pin, synchronised.
  logic int0_s; // External interrupt 0 pin level, synchronised.
  logic int1_s; // External interrupt 1 pin level, synchronised.

  pin_sync #(.WIDTH(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({external_interrupt1_pin_n, external_interrupt0_pin_n,
             timer1_count_pin, timer0_count_pin}),
    .pin_out(pins_s)
  );

  assign cnt0_s = pins_s[0];
  assign cnt1_s = pins_s[1];
  assign int0_s = pins_s[2];
  assign int1_s = pins_s[3];

  // ************************************************************
  // State declarations.
  // ************************************************************
  logic [2:0] mc_cnt_reg, mc_cnt_next; // Machine-cycle phase.
  logic mc_strobe; // High for one clock per machine cycle.
  logic [7:0] ctrl_reg, ctrl_next; // Run, flag and type bits.
  logic [7:0] mode_reg, mode_next; // Gate, select and mode fields.
  logic [7:0] tl0_reg, tl0_next; // Timer 0 low byte.
  logic [7:0] th0_reg, th0_next; // Timer 0 high byte.
  logic [7:0] tl1_reg, tl1_next; // Timer 1 low byte.
  logic [7:0] th1_reg, th1_next; // Timer 1 high byte.
  logic [1:0] samp_reg, samp_next; // Count pin samples, this cycle.
  logic [1:0] prev_reg, prev_next; // Count pin samples, last cycle.
  logic [1:0] int_prev_reg, int_prev_next; // Last interrupt pin levels.
  logic [31:0] prdata_reg, prdata_next; // Read data captured at setup.
  logic ovf1_reg, ovf1_next; // Registered timer 1 rollover.

  // ************************************************************
  // One counting step for modes 0, 1, 2 and the split low byte.
  // ************************************************************
  // Returns {overflow, high byte, low byte}.
  function automatic logic [16:0] count_step(
    input timer_mode_e mode,
    input logic [7:0] tl,
    input logic [7:0] th,
    input logic inc
  );
    logic [16:0] res;
    res = {1'b0, th, tl};
    if (inc) begin
      unique case (mode)
        MODE_13BIT: begin
          // Upper three low bits are left alone; they mean nothing.
          res[4:0] = tl[4:0] + 5'h01;
          if (tl[4:0] == 5'h1F) begin
            res[15:8] = th + 8'h01;
            res[16] = (th == 8'hFF);
          end
        end
        MODE_16BIT: res = {1'b0, th, tl} + 17'h00001;
        MODE_RELOAD: begin
          if (tl == 8'hFF) begin
            res[7:0] = th;
            res[16] = 1'b1;
          end else begin
            res[7:0] = tl + 8'h01;
          end
        end
        MODE_SPLIT: begin
          res[7:0] = tl + 8'h01;
          res[16] = (tl == 8'hFF);
        end
      endcase
    end
    return res;
  endfunction

  // ************************************************************
  // Timer datapath control.
  // ************************************************************
  timer_mode_e t0_mode; // Timer 0 mode field.
  timer_mode_e t1_mode; // Timer 1 mode field.
  logic t0_split; // Timer 0 runs as two 8-bit halves.
  logic gate0_ok, gate1_ok; // Gate allows counting.
  logic inc0, inc1; // Count pulses delivered to each timer.
  logic edge0, edge1; // Falling edges seen on the count pins.
  logic th0_inc; // Split high byte count pulse.
  logic th0_ovf; // Split high byte rollover.
  logic [16:0] res0, res1; // Counting step results.
  logic ovf0, ovf1; // Rollovers this clock.
  logic tf1_set; // Source that sets the timer 1 flag.
  logic ie0_set, ie1_set; // External interrupt detections.

  always_comb begin
    t0_mode = timer_mode_e'(mode_reg[MODE_T0_LSB +: 2]);
    t1_mode = timer_mode_e'(mode_reg[MODE_T1_LSB +: 2]);
    t0_split = (t0_mode == MODE_SPLIT);
    // A set gate bit hands control to the interrupt pin level.
    gate0_ok = !mode_reg[MODE_T0_GATE] || int0_s;
    gate1_ok = !mode_reg[MODE_T1_GATE] || int1_s;
    // Edge seen between the last two samples counts at this strobe.
    edge0 = prev_reg[0] && !samp_reg[0];
    edge1 = prev_reg[1] && !samp_reg[1];
    // Select bit: clear counts machine cycles, set counts pin edges.
    inc0 = mc_strobe && ctrl_reg[CTRL_TR0] && gate0_ok &&
           (mode_reg[MODE_T0_CT] ? edge0 : 1'b1);
    // Mode 3 on timer 1 acts as a cleared run bit.
    inc1 = mc_strobe && ctrl_reg[CTRL_TR1] && gate1_ok &&
           (t1_mode != MODE_SPLIT) &&
           (mode_reg[MODE_T1_CT] ? edge1 : 1'b1);
    res0 = count_step(t0_mode, tl0_reg, th0_reg, inc0);
    res1 = count_step(t1_mode, tl1_reg, th1_reg, inc1);
    ovf0 = res0[16];
    ovf1 = res1[16];
    // The split high byte counts machine cycles under timer 1's run.
    th0_inc = t0_split && mc_strobe && ctrl_reg[CTRL_TR1];
    th0_ovf = th0_inc && (th0_reg == 8'hFF);
    // Timer 1 loses its flag to timer 0's high byte in split mode.
    tf1_set = t0_split ? th0_ovf : ovf1;
    // Type bit set: falling edge; clear: low level.
    ie0_set = ctrl_reg[CTRL_IT0] ? (int_prev_reg[0] && !int0_s)
                                 : !int0_s;
    ie1_set = ctrl_reg[CTRL_IT1] ? (int_prev_reg[1] && !int1_s)
                                 : !int1_s;
  end

  // ************************************************************
  // APB decode.
  // ************************************************************
  logic acc; // Access phase of a transfer.
  logic wr; // Write that takes effect this edge.
  logic hit; // Address maps to a register.
  logic wr_ctrl, wr_mode, wr_tl0, wr_th0, wr_tl1, wr_th1; // Write strobes.
  logic [7:0] rd_mux; // Register selected for reading.

  always_comb begin
    acc = psel && penable;
    wr = acc && pwrite;
    hit = 1'b1;
    rd_mux = 8'h00;
    case (paddr)
      ADDR_CTRL: rd_mux = ctrl_reg;
      ADDR_MODE: rd_mux = mode_reg;
      ADDR_TL0: rd_mux = tl0_reg;
      ADDR_TH0: rd_mux = th0_reg;
      ADDR_TL1: rd_mux = tl1_reg;
      ADDR_TH1: rd_mux = th1_reg;
      default: hit = 1'b0;
    endcase
    wr_ctrl = wr && (paddr == ADDR_CTRL);
    wr_mode = wr && (paddr == ADDR_MODE);
    wr_tl0 = wr && (paddr == ADDR_TL0);
    wr_th0 = wr && (paddr == ADDR_TH0);
    wr_tl1 = wr && (paddr == ADDR_TL1);
    wr_th1 = wr && (paddr == ADDR_TH1);
  end

  // Zero wait states; unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = prdata_reg;

  // ************************************************************
  // Next-state logic for every register.
  // ************************************************************
  // Software writes win over counting on the same edge, so a load
  // is never half-overwritten by an increment.
  always_comb begin
    mc_cnt_next = mc_strobe ? 3'h0 : mc_cnt_reg + 3'h1;
    samp_next = mc_strobe ? {cnt1_s, cnt0_s} : samp_reg;
    prev_next = mc_strobe ? samp_reg : prev_reg;
    int_prev_next = {int1_s, int0_s};
    prdata_next = (psel && !penable) ? {24'h000000, rd_mux} : prdata_reg;
    ovf1_next = ovf1;
    mode_next = wr_mode ? pwdata[7:0] : mode_reg;
    // Run bits change only by software; counts are not touched.
    ctrl_next = wr_ctrl ? pwdata[7:0] : ctrl_reg;
    // Flags: acknowledge clears, but a set on the same edge wins.
    ctrl_next[CTRL_TF0] = (ctrl_next[CTRL_TF0] && !timer0_vector_ack) ||
                          ovf0;
    ctrl_next[CTRL_TF1] = (ctrl_next[CTRL_TF1] && !timer1_vector_ack) ||
                          tf1_set;
    ctrl_next[CTRL_IE0] = (ctrl_next[CTRL_IE0] && !extint0_vector_ack) ||
                          ie0_set;
    ctrl_next[CTRL_IE1] = (ctrl_next[CTRL_IE1] && !extint1_vector_ack) ||
                          ie1_set;
    tl0_next = wr_tl0 ? pwdata[7:0] : res0[7:0];
    if (wr_th0) begin
      th0_next = pwdata[7:0];
    end else if (t0_split) begin
      th0_next = th0_inc ? th0_reg + 8'h01 : th0_reg;
    end else begin
      th0_next = res0[15:8];
    end
    tl1_next = wr_tl1 ? pwdata[7:0] : res1[7:0];
    th1_next = wr_th1 ? pwdata[7:0] : res1[15:8];
  end

  // Registers only; all reset values are constants.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_cnt_reg <= 3'h0;
      ctrl_reg <= CTRL_RESET;
      mode_reg <= MODE_RESET;
      tl0_reg <= COUNT_RESET;
      th0_reg <= COUNT_RESET;
      tl1_reg <= COUNT_RESET;
      th1_reg <= COUNT_RESET;
      samp_reg <= 2'h3;
      prev_reg <= 2'h3;
      int_prev_reg <= 2'h3;
      prdata_reg <= 32'h00000000;
      ovf1_reg <= 1'b0;
    end else begin
      mc_cnt_reg <= mc_cnt_next;
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      tl0_reg <= tl0_next;
      th0_reg <= th0_next;
      tl1_reg <= tl1_next;
      th1_reg <= th1_next;
      samp_reg <= samp_next;
      prev_reg <= prev_next;
      int_prev_reg <= int_prev_next;
      prdata_reg <= prdata_next;
      ovf1_reg <= ovf1_next;
    end
  end

  assign mc_strobe = (mc_cnt_reg == MC_LAST);
  assign timer0_overflow_flag = ctrl_reg[CTRL_TF0];
  assign timer1_overflow_flag = ctrl_reg[CTRL_TF1];
  assign extint0_detect_flag = ctrl_reg[CTRL_IE0];
  assign extint1_detect_flag = ctrl_reg[CTRL_IE1];
  // Still driven in every mode of timer 0 so baud logic keeps working.
  assign timer1_overflow_pulse = ovf1_reg;

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_mcycle_period: assert property (
    mc_strobe |=> (!mc_strobe) [*5] ##1 mc_strobe)
    else $error("machine strobe period is not six clocks");

  a_tf0_on_ovf: assert property (
    ovf0 |=> timer0_overflow_flag)
    else $error("timer 0 overflow did not set its flag");

  a_stopped_hold: assert property (
    (!ctrl_reg[CTRL_TR0] && !wr_tl0) |=> $stable(tl0_reg))
    else $error("timer 0 low byte moved while stopped");

  a_reload_value: assert property (
    (t0_mode == MODE_RELOAD && ovf0 && !wr_tl0 && !wr_th0 && !wr_mode)
    |=> (tl0_reg == $past(th0_reg)) && $stable(th0_reg))
    else $error("mode 2 reload did not copy the high byte");

  a_t1_split_hold: assert property (
    (t1_mode == MODE_SPLIT && !wr_tl1 && !wr_th1)
    |=> $stable({th1_reg, tl1_reg}))
    else $error("timer 1 counted in mode 3");

  a_th0_split_cnt: assert property (
    (th0_inc && !wr_th0) |=> th0_reg == $past(th0_reg) + 8'h01)
    else $error("split high byte missed a machine cycle");

  a_mode0_upper: assert property (
    (t0_mode == MODE_13BIT && !wr_tl0) |=> $stable(tl0_reg[7:5]))
    else $error("mode 0 touched the unused low-byte bits");

  a_edge_flag: assert property (
    (ctrl_reg[CTRL_IT0] && $fell(int0_s)) |-> ##1 extint0_detect_flag
    )
    else $error("falling edge did not set external flag 0");

  // Watches timer 1, the timer that the event-counting traffic uses.
  a_pin_count: assert property (
    (mode_reg[MODE_T1_CT] && t1_mode == MODE_16BIT && ctrl_reg[CTRL_TR1]
     && gate1_ok && mc_strobe && !edge1 && !wr_tl1 && !wr_mode)
    |=> $stable(tl1_reg))
    else $error("counter advanced with no pin edge");

endmodule // dual_timer_counter

`default_nettype wire

// >>> pin_source.sv
// Board-side model of the count and external interrupt pins.
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  input wire logic pclk, // Clock that paces pin changes.
  input wire logic [3:0] level_req, // Wanted levels: t0, t1, int0_n, int1_n.
  output logic [3:0] pin_lvl // Levels seen by the block.
);
  // All pins idle high, like the synchroniser's reset level, so no false
  // falling edge is seen just after reset.
  initial pin_lvl = 4'hF;

  // Pins move just after a rising edge; the block has to synchronise them.
  always @(posedge pclk) begin
    pin_lvl <= level_req;
  end
endmodule // pin_source

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the dual timer/counter block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end

module testbench;
  import timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr; // Byte address.
  logic [31:0] pwdata, prdata, rdat; // Bus data and last read word.
  logic [3:0] lvl, pins, ack; // Pin requests, pin levels, acknowledges.
  logic tf0, tf1, ie0, ie1, pls; // Flags and baud pulse.
  logic [7:0] v, w; // Read-back bytes.
  int num_errors = 0;
  int tests_run = 0;
  int n; // Edge counts.
  wire logic [4:0] flg = {pls, tf1, tf0, ie1, ie0};

  dual_timer_counter u_dual_timer_counter (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_count_pin(pins[0]), .timer1_count_pin(pins[1]),
    .external_interrupt0_pin_n(pins[2]), .external_interrupt1_pin_n(pins[3]),
    .timer0_vector_ack(ack[0]), .timer1_vector_ack(ack[1]),
    .extint0_vector_ack(ack[2]), .extint1_vector_ack(ack[3]),
    .timer0_overflow_flag(tf0), .timer1_overflow_flag(tf1),
    .extint0_detect_flag(ie0), .extint1_detect_flag(ie1),
    .timer1_overflow_pulse(pls));
  pin_source u_pin_source (.pclk(pclk), .level_req(lvl), .pin_lvl(pins));

  // 25 MHz clock.
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  // ********
  // Bus and wait helpers.
  // ********
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d.", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr} <= {2'h2, wr, a};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rdat = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    // Let the edge's register updates land before the caller looks.
    #1;
    if (k >= 50) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] o);
    apb(1'h0, a, 8'h00);
    o = rdat[7:0];
  endtask

  // Counts edges until a flag rises; a bounded wait so a dead flag ends.
  task automatic wait_bit(input int b, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while (flg[b] !== 1'h1 && c < 400);
    if (c >= 400) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic pulse(input int b);
    @(posedge pclk);
    ack[b] <= 1'h1;
    @(posedge pclk);
    ack[b] <= 1'h0;
    #1;
  endtask

  // ********
  // Scenarios.
  // ********
  task automatic t_regs();
    rd(ADDR_CTRL, v);
    `CHK(v, CTRL_RESET)
    rd(ADDR_MODE, v);
    `CHK(v, MODE_RESET)
    wr(ADDR_MODE, 8'hA5);
    rd(ADDR_MODE, v);
    `CHK(v, 8'hA5)
    wr(12'h000, 8'h5A);
    `CHK(err, 1'h1)
    rd(12'h000, v);
    `CHK(rdat, 32'h00000000)
    $display("Test regs done.");
  endtask

  // A 16-bit count rolls from FFFF to 0000 and raises the flag.
  task automatic t_mode1();
    wr(ADDR_TH0, 8'hFF);
    wr(ADDR_TL0, 8'hFE);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CTRL, 8'h10); // Software starts timer 0.
    wait_bit(2, n);
    wr(ADDR_CTRL, 8'h00);
    `CHK(tf0, 1'h0)
    rd(ADDR_TL0, v);
    `CHK(v, 8'h00)
    rd(ADDR_TH0, v);
    `CHK(v, 8'h00)
    $display("Test mode1 done.");
  endtask

  // The carry leaves the low byte after five bits.
  task automatic t_mode0();
    wr(ADDR_TH0, 8'hFF);
    wr(ADDR_TL0, 8'h1F);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CTRL, 8'h10);
    wait_bit(2, n);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TH0, v);
    `CHK(v, 8'h00)
    rd(ADDR_TL0, v);
    `CHK(v[4:0], 5'h00)
    $display("Test mode0 done.");
  endtask

  // Reload from FD gives three strobes, 18 clocks, between overflows.
  task automatic t_mode2();
    wr(ADDR_TH0, 8'hFD);
    wr(ADDR_TL0, 8'hFF);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_CTRL, 8'h10);
    wait_bit(2, n);
    pulse(0);
    `CHK(tf0, 1'h0)
    wait_bit(2, n);
    `CHK(n + 2, 18)
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TH0, v);
    `CHK(v, 8'hFD)
    $display("Test mode2 done.");
  endtask

  // Gate holds the count while the pin is low; edge flag fires once.
  task automatic t_gate();
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_CTRL, 8'h01);
    lvl[2] <= 1'h0;
    repeat (8) @(posedge pclk);
    #1;
    `CHK(ie0, 1'h1)
    pulse(2);
    `CHK(ie0, 1'h0)
    wr(ADDR_CTRL, 8'h11);
    repeat (30) @(posedge pclk);
    #1;
    `CHK(ie0, 1'h0)
    rd(ADDR_TL0, v);
    `CHK(v, 8'h00)
    lvl[2] <= 1'h1;
    repeat (30) @(posedge pclk);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_TL0, v);
    `CHK(v != 8'h00, 1'h1)
    $display("Test gate done.");
  endtask

  // A low level keeps setting the flag even across an acknowledge.
  task automatic t_level();
    wr(ADDR_CTRL, 8'h00);
    lvl[3] <= 1'h0;
    repeat (8) @(posedge pclk);
    pulse(3);
    repeat (2) @(posedge pclk);
    #1;
    `CHK(ie1, 1'h1)
    lvl[3] <= 1'h1;
    repeat (8) @(posedge pclk);
    pulse(3);
    `CHK(ie1, 1'h0)
    $display("Test level done.");
  endtask

  // Split mode, then timer 1 as baud source, then timer 1 parked.
  task automatic t_split();
    wr(ADDR_TL0, 8'h00);
    wr(ADDR_TH0, 8'hFF);
    wr(ADDR_MODE, 8'h13);
    wr(ADDR_CTRL, 8'h40);
    wait_bit(3, n);
    pulse(1);
    `CHK(tf1, 1'h0)
    wr(ADDR_CTRL, 8'h00);
    `CHK(tf0, 1'h0)
    rd(ADDR_TL0, v);
    `CHK(v, 8'h00)
    rd(ADDR_TH0, v);
    `CHK(v, 8'h00)
    wr(ADDR_TH1, 8'h00); // Zero reload lets a running count climb.
    wr(ADDR_TL1, 8'hFF);
    wr(ADDR_MODE, 8'h23);
    wr(ADDR_CTRL, 8'h40);
    wait_bit(4, n);
    `CHK(n < 20, 1'h1)
    wr(ADDR_MODE, 8'h33);
    rd(ADDR_TL1, w);
    repeat (20) @(posedge pclk);
    rd(ADDR_TL1, v);
    `CHK(v, w)
    wr(ADDR_MODE, 8'h23); // Leaving mode 3 turns timer 1 back on.
    repeat (20) @(posedge pclk);
    rd(ADDR_TL1, v);
    `CHK(v != w, 1'h1)
    wr(ADDR_CTRL, 8'h00);
    $display("Test split done.");
  endtask

  // Three falling edges on the count pin give three counts.
  task automatic t_count();
    wr(ADDR_MODE, 8'h50);
    wr(ADDR_TL1, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    repeat (3) begin
      @(posedge pclk);
      lvl[1] <= 1'h1;
      repeat (12) @(posedge pclk);
      lvl[1] <= 1'h0;
      repeat (12) @(posedge pclk);
    end
    repeat (24) @(posedge pclk);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_TL1, v);
    `CHK(v, 8'h03)
    $display("Test count done.");
  endtask

  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ack = 4'h0;
    lvl = 4'hF;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_mode1();
    t_mode0();
    t_mode2();
    t_gate();
    t_level();
    t_split();
    t_count();
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
